// ---- mcgd_regs.sv ----
`default_nettype none
module mcgd_regs #(
  parameter int NUM_PINS    = 8,
  parameter int NUM_ANALOG  = 12
) (
  // Clock and reset.
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      sw_reset,
  // Register access from the serial host port.
  input  wire mcgd_pkg::mcgd_req_t       req,
  output mcgd_pkg::mcgd_rsp_t            rsp,
  // Configuration held elsewhere in the device.
  input  wire logic                      monitor_enable,
  input  wire logic [NUM_PINS-1:0]       pin_direction_bit,
  input  wire logic [NUM_PINS-1:0]       pin_level_sense,
  // General-purpose pins.
  output logic [NUM_PINS-1:0]            gpio_o,
  output logic [NUM_PINS-1:0]            gpio_oe,
  // Analogue output power.
  output logic [NUM_ANALOG-1:0]          analog_output_on,
  // Conversion engine.
  input  wire logic                      conv_done,
  output logic                           conv_start,
  output logic [mcgd_pkg::CH_W-1:0]      conv_channel,
  output logic                           conv_busy
);

  initial begin
    if (NUM_PINS != 8) begin
      $error("mcgd_regs: the output data register serves exactly eight pins");
    end
    if (NUM_ANALOG != 2 * mcgd_pkg::PWR_GROUP_W) begin
      $error("mcgd_regs: the power register serves two groups of six outputs");
    end
    if (mcgd_pkg::NUM_CH != mcgd_pkg::NUM_VOLTAGE_CH + 2) begin
      $error("mcgd_regs: channel list must be the voltage inputs plus two temperatures");
    end
  end

  logic [7:0]  pin_out_level_q;
  logic [7:0]  vin_low_include_q;
  logic [7:0]  vin_high_include_q;
  logic [1:0]  temp_include_q;
  logic [15:0] power_enable_q;
  logic [15:0] rdata_d;
  logic        rsp_valid_q;
  logic [15:0] rsp_rdata_q;
  logic        wr_gpio;
  logic        wr_vlow;
  logic        wr_vhigh;
  logic        wr_temp;
  logic        wr_pwr;
  logic [mcgd_pkg::NUM_CH-1:0] include_mask;

  // Address match on a write strobe.
  function automatic logic hit(input mcgd_pkg::mcgd_req_t r, input logic [7:0] off);
    return r.wr && (r.addr == off);
  endfunction : hit

  assign wr_gpio  = hit(req, mcgd_pkg::OFF_GPIO_OUTPUT_LEVELS);
  assign wr_vlow  = hit(req, mcgd_pkg::OFF_VOLTAGE_INPUT_SELECT_LOW);
  assign wr_vhigh = hit(req, mcgd_pkg::OFF_VOLTAGE_INPUT_SELECT_HIGH);
  assign wr_temp  = hit(req, mcgd_pkg::OFF_TEMPERATURE_CHANNEL_SELECT);
  assign wr_pwr   = hit(req, mcgd_pkg::OFF_ANALOG_OUTPUT_POWER_ENABLE);

  // Output data register; upper byte is not stored. Soft reset outranks a
  // write in the same cycle, so a reset request is never half undone.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_out_level_q <= mcgd_pkg::RST_GPIO_OUTPUT_LEVELS;
    end else if (sw_reset) begin
      pin_out_level_q <= mcgd_pkg::RST_GPIO_OUTPUT_LEVELS;
    end else if (wr_gpio) begin
      pin_out_level_q <= req.wdata[7:0];
    end
  end

  // Low voltage input selector; a cleared bit drops that input from the walk.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vin_low_include_q <= mcgd_pkg::RST_VOLTAGE_SELECT;
    end else if (sw_reset) begin
      vin_low_include_q <= mcgd_pkg::RST_VOLTAGE_SELECT;
    end else if (wr_vlow) begin
      vin_low_include_q <= req.wdata[7:0];
    end
  end

  // High voltage input selector, same layout for inputs nine to sixteen.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vin_high_include_q <= mcgd_pkg::RST_VOLTAGE_SELECT;
    end else if (sw_reset) begin
      vin_high_include_q <= mcgd_pkg::RST_VOLTAGE_SELECT;
    end else if (wr_vhigh) begin
      vin_high_include_q <= req.wdata[7:0];
    end
  end

  // Temperature selector keeps only its two live bits; bit 1 is local.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      temp_include_q <= mcgd_pkg::RST_TEMP_SELECT;
    end else if (sw_reset) begin
      temp_include_q <= mcgd_pkg::RST_TEMP_SELECT;
    end else if (wr_temp) begin
      temp_include_q[1] <= req.wdata[mcgd_pkg::LOCAL_TEMP_BIT];
      temp_include_q[0] <= req.wdata[mcgd_pkg::REMOTE_TEMP_BIT];
    end
  end

  // Power enables: all sixteen bits are stored, including the spare ones,
  // so software that writes them back reads what it wrote.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      power_enable_q <= mcgd_pkg::RST_POWER_ENABLE;
    end else if (sw_reset) begin
      power_enable_q <= mcgd_pkg::RST_POWER_ENABLE;
    end else if (wr_pwr) begin
      power_enable_q <= req.wdata;
    end
  end

  // Each analogue output is on while its enable is one. The spare bits have
  // no output behind them and only come back on a read.
  assign analog_output_on = {
    power_enable_q[mcgd_pkg::PWR_HIGH_LSB +: mcgd_pkg::PWR_GROUP_W],
    power_enable_q[mcgd_pkg::PWR_LOW_LSB  +: mcgd_pkg::PWR_GROUP_W]
  };

  // Read multiplexer; reserved bits, the reserved slot and unmapped
  // addresses all answer zero. The address is decoded every cycle, but
  // only a read strobe captures the result.
  always_comb begin
    rdata_d = mcgd_pkg::READ_ZERO;
    case (req.addr)
      mcgd_pkg::OFF_GPIO_OUTPUT_LEVELS:        rdata_d[7:0] = pin_out_level_q;
      mcgd_pkg::OFF_VOLTAGE_INPUT_SELECT_LOW:  rdata_d[7:0] = vin_low_include_q;
      mcgd_pkg::OFF_VOLTAGE_INPUT_SELECT_HIGH: rdata_d[7:0] = vin_high_include_q;
      mcgd_pkg::OFF_TEMPERATURE_CHANNEL_SELECT: begin
        rdata_d[mcgd_pkg::LOCAL_TEMP_BIT]  = temp_include_q[1];
        rdata_d[mcgd_pkg::REMOTE_TEMP_BIT] = temp_include_q[0];
      end
      mcgd_pkg::OFF_ANALOG_OUTPUT_POWER_ENABLE: rdata_d = power_enable_q;
      default:                                  rdata_d = mcgd_pkg::READ_ZERO;
    endcase
  end

  // Answer strobe follows every read strobe by exactly one cycle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= req.rd;
    end
  end

  // Read data is captured only on a read strobe, so it stands until the
  // next read and a later write cannot disturb an answer still in use.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rsp_rdata_q <= mcgd_pkg::READ_ZERO;
    end else if (req.rd) begin
      rsp_rdata_q <= rdata_d;
    end
  end

  // Both answer fields travel to the host port together.
  assign rsp = '{valid: rsp_valid_q, rdata: rsp_rdata_q};

  // Pin level: the stored level is inverted for active-low pins, so a one
  // in the output data register always means the asserted pin state.
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      gpio_o[p] = pin_out_level_q[p] ^ ~pin_level_sense[p];
    end
  end

  // Pin enable: only output pins drive, so input pins stay free for the far
  // side. The level above is kept live regardless, so turning a pin into an
  // output shows the stored level in the very same cycle.
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      gpio_oe[p] = pin_direction_bit[p];
    end
  end

  // Channel order: voltage inputs 1 to 16, then local, then remote.
  // The sequencer numbers its channels by this bit order.
  assign include_mask = {temp_include_q[0], temp_include_q[1],
                         vin_high_include_q, vin_low_include_q};

  // Sequencer steps only while monitoring is enabled; a conversion already
  // launched is allowed to finish after the enable drops.
  mcgd_sequencer #(
    .CHANNELS (mcgd_pkg::NUM_CH),
    .CW       (mcgd_pkg::CH_W)
  ) u_seq (
    .mclk         (mclk),
    .rst          (rst),
    .run          (monitor_enable),
    .include_mask (include_mask),
    .conv_done    (conv_done),
    .conv_start   (conv_start),
    .chan_q       (conv_channel),
    .busy         (conv_busy)
  );

endmodule : mcgd_regs
`default_nettype wire

// ---- mcgd_pkg.sv ----
`default_nettype none
// Shared map, layouts and reset values of the monitor register slice.
package mcgd_pkg;

  // Register offsets on the host register port.
  localparam logic [7:0] OFF_GPIO_OUTPUT_LEVELS        = 8'h08;
  localparam logic [7:0] OFF_VOLTAGE_INPUT_SELECT_LOW  = 8'h09;
  localparam logic [7:0] OFF_VOLTAGE_INPUT_SELECT_HIGH = 8'h0a;
  localparam logic [7:0] OFF_TEMPERATURE_CHANNEL_SELECT = 8'h0b;
  localparam logic [7:0] OFF_ANALOG_OUTPUT_POWER_ENABLE = 8'h0c;
  localparam logic [7:0] OFF_RESERVED_SLOT             = 8'h0d;

  // Field positions.
  localparam int LOCAL_TEMP_BIT  = 7;
  localparam int REMOTE_TEMP_BIT = 6;
  localparam int PWR_HIGH_LSB    = 8;
  localparam int PWR_LOW_LSB     = 0;
  localparam int PWR_GROUP_W     = 6;

  // Reset values.
  localparam logic [7:0]  RST_GPIO_OUTPUT_LEVELS = 8'h00;
  localparam logic [7:0]  RST_VOLTAGE_SELECT     = 8'hff;
  localparam logic [1:0]  RST_TEMP_SELECT        = 2'h3;
  localparam logic [15:0] RST_POWER_ENABLE       = 16'hffff;
  localparam logic [15:0] READ_ZERO              = 16'h0000;

  // Channel numbering of the round-robin sequence.
  localparam int NUM_VOLTAGE_CH = 16;
  localparam int NUM_CH         = 18;
  localparam int CH_W           = 5;

  // One register access from the serial host port.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } mcgd_req_t;

  // One register read answer.
  typedef struct packed {
    logic        valid;
    logic [15:0] rdata;
  } mcgd_rsp_t;

endpackage : mcgd_pkg
`default_nettype wire

// ---- mcgd_sequencer.sv ----
`default_nettype none
// Round-robin channel stepper: walks included channels while allowed to run.
module mcgd_sequencer #(
  parameter int CHANNELS = 18,
  parameter int CW       = 5
) (
  // Clock and reset.
  input  wire logic                mclk,
  input  wire logic                rst,
  // Control from the register slice.
  input  wire logic                run,
  input  wire logic [CHANNELS-1:0] include_mask,
  // Conversion engine handshake.
  input  wire logic                conv_done,
  output logic                     conv_start,
  output logic [CW-1:0]            chan_q,
  output logic                     busy
);

  initial begin
    if (CHANNELS < 2 || CHANNELS > (1 << CW)) begin
      $error("mcgd_sequencer: channel count does not fit the channel index");
    end
  end

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_START = 3'b010,
    ST_WAIT  = 3'b100
  } mcgd_state_t;

  mcgd_state_t state_q;
  logic [CW-1:0] chan_d;

  // First included channel after the current one, wrapping around.
  function automatic logic [CW-1:0] next_chan(input logic [CW-1:0] cur,
                                              input logic [CHANNELS-1:0] mask);
    logic [CW-1:0] pick;
    int            idx;
    logic          found;
    pick  = cur;
    found = 1'b0;
    for (int i = 1; i <= CHANNELS; i++) begin
      idx = (int'(cur) + i) % CHANNELS;
      if (!found && mask[idx]) begin
        pick  = CW'(idx);
        found = 1'b1;
      end
    end
    return pick;
  endfunction : next_chan

  assign chan_d = next_chan(chan_q, include_mask);

  // A conversion already under way is allowed to finish when the run level
  // drops, so the engine is never left with a half-taken sample.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:  if (run && |include_mask) state_q <= ST_START;
        ST_START: state_q <= ST_WAIT;
        ST_WAIT:  if (conv_done) state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  // Channel advances only when a new conversion is launched.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      chan_q <= CW'(CHANNELS - 1);
    end else if (state_q == ST_IDLE && run && |include_mask) begin
      chan_q <= chan_d;
    end
  end

  assign conv_start = (state_q == ST_START);
  assign busy       = (state_q != ST_IDLE);

endmodule : mcgd_sequencer
`default_nettype wire

// ---- mcgd_regs_props.sv ----
`default_nettype none
// Port-level relations of the register slice; no shadow copy of the registers is kept.
module mcgd_regs_chk #(
  parameter int NUM_PINS   = 8,
  parameter int NUM_ANALOG = 12
) (
  // Clock and reset.
  input wire logic                      mclk,
  input wire logic                      rst,
  input wire logic                      sw_reset,
  // Register port.
  input wire mcgd_pkg::mcgd_req_t       req,
  input wire mcgd_pkg::mcgd_rsp_t       rsp,
  // Pins, analogue power and sequencer.
  input wire logic                      monitor_enable,
  input wire logic [NUM_PINS-1:0]       pin_direction_bit,
  input wire logic [NUM_PINS-1:0]       pin_level_sense,
  input wire logic [NUM_PINS-1:0]       gpio_o,
  input wire logic [NUM_PINS-1:0]       gpio_oe,
  input wire logic [NUM_ANALOG-1:0]     analog_output_on,
  input wire logic                      conv_done,
  input wire logic                      conv_start,
  input wire logic [mcgd_pkg::CH_W-1:0] conv_channel,
  input wire logic                      conv_busy
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_oe; gpio_oe == pin_direction_bit; endproperty
  a_oe: assert property (p_oe) else $error("pin enable differs from direction");
  property p_pin; req.wr && req.addr == 8'h08 && !sw_reset
    |=> gpio_o == ($past(req.wdata[7:0]) ^ ~pin_level_sense); endproperty
  a_pin: assert property (p_pin) else $error("pin level wrong after write");
  property p_swr; sw_reset |=> gpio_o == ~pin_level_sense && analog_output_on == '1;
  endproperty
  a_swr: assert property (p_swr) else $error("soft reset left outputs wrong");
  property p_pwr; req.wr && req.addr == 8'h0c && !sw_reset
    |=> analog_output_on == {$past(req.wdata[13:8]), $past(req.wdata[5:0])}; endproperty
  a_pwr: assert property (p_pwr) else $error("power enables wrong after write");
  property p_rsv; req.rd && req.addr == 8'h0d |=> rsp.valid && rsp.rdata == 16'h0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved slot read not zero");
  property p_hi; req.rd && req.addr inside {[8'h08:8'h0b]} |=> rsp.rdata[15:8] == 8'h00;
  endproperty
  a_hi: assert property (p_hi) else $error("upper byte read not zero");
  // A start may only follow a cycle in which monitoring was allowed.
  property p_start; conv_start |-> $past(monitor_enable) && conv_busy; endproperty
  a_start: assert property (p_start) else $error("start without enable");
  property p_pulse; conv_start |=> !conv_start && conv_busy; endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse too long");
  property p_done; conv_busy && conv_done && !conv_start |=> !conv_busy; endproperty
  a_done: assert property (p_done) else $error("busy stuck after done");
endmodule : mcgd_regs_chk
`default_nettype wire

// ---- mcgd_regs_tb.sv ----
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module mcgd_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                mclk = 1'b0;
  logic                rst, sw_reset, monitor_enable, conv_done, conv_start, conv_busy;
  logic [7:0]          pin_direction_bit, pin_level_sense, gpio_o, gpio_oe;
  logic [11:0]         analog_output_on;
  logic [4:0]          conv_channel;
  logic [15:0]         lfsr;
  logic [15:0]         mem [0:255];
  mcgd_pkg::mcgd_req_t req;
  mcgd_pkg::mcgd_rsp_t rsp;
  int                  bad_count, checks, cur;

  mcgd_regs dut (.mclk, .rst, .sw_reset, .req, .rsp, .monitor_enable, .pin_direction_bit,
    .pin_level_sense, .gpio_o, .gpio_oe, .analog_output_on, .conv_done, .conv_start,
    .conv_channel, .conv_busy);

  // Free-running bench clock, 40 ns period.
  always #20 mclk = ~mclk;

  // Writable bits of each offset; unmapped offsets keep nothing.
  function automatic logic [15:0] msk(int a);
    return a == 12 ? 16'hffff : a == 11 ? 16'h00c0 : a inside {[8:10]} ? 16'h00ff : 16'h0000;
  endfunction : msk

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  task automatic mreset();
    foreach (mem[i]) mem[i] = 16'h0000;
    mem[9] = 16'h00ff;
    mem[10] = 16'h00ff;
    mem[11] = 16'h00c0;
    mem[12] = 16'hffff;
  endtask : mreset

  // Next included channel after c, wrapping; 16 is local, 17 remote temperature.
  function automatic int nxt(int c);
    logic [17:0] m;
    m = {mem[11][6], mem[11][7], mem[10][7:0], mem[9][7:0]};
    for (int i = 1; i <= 18; i++) if (m[(c + i) % 18]) return (c + i) % 18;
    return c;
  endfunction : nxt

  // One register access, a single-cycle strobe, then the outputs are compared.
  task automatic acc(bit w, logic [7:0] a, logic [15:0] d);
    // Software keeps ones in the spare power-enable bits.
    if (w && a == 8'h0c) d = d | 16'hc0c0;
    @(negedge mclk);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge mclk);
    req = '0;
    if (w) begin
      mem[a] = d & msk(int'(a));
      `CHK("no answer", 1'b0, rsp.valid)
    end else begin
      `CHK("valid", 1'b1, rsp.valid)
      `CHK("rdata", mem[a], rsp.rdata)
    end
    `CHK("gpio_o", mem[8][7:0] ^ ~pin_level_sense, gpio_o)
    `CHK("gpio_oe", pin_direction_bit, gpio_oe)
    `CHK("analog", {mem[12][13:8], mem[12][5:0]}, analog_output_on)
  endtask : acc

  task automatic read_all();
    for (int a = 8; a < 15; a++) acc(1'b0, 8'(a), 16'h0000);
  endtask : read_all

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  // Main sequence: reset values, random traffic, soft reset, round-robin walk.
  initial begin
    {rst, sw_reset, monitor_enable, conv_done, req} = '0;
    rst = 1'b1;
    pin_direction_bit = 8'h00;
    pin_level_sense = 8'hff;
    lfsr = 16'h0032;
    cur = 17;
    mreset();
    repeat (8) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    read_all();
    $display("test reset values done");
    repeat (60) begin
      pin_direction_bit = 8'(rnd());
      pin_level_sense = 8'(rnd());
      acc(1'b1, 8'(8 + rnd() % 7), rnd());
      acc(1'b0, 8'(8 + rnd() % 7), 16'h0000);
    end
    $display("test random access done");
    @(negedge mclk) sw_reset = 1'b1;
    @(negedge mclk) sw_reset = 1'b0;
    mreset();
    read_all();
    $display("test soft reset done");
    acc(1'b1, 8'h09, rnd() | 16'h0001);
    acc(1'b1, 8'h0a, rnd());
    acc(1'b1, 8'h0b, rnd());
    monitor_enable = 1'b1;
    repeat (30) begin
      for (int n = 0; n < 50 && conv_start !== 1'b1; n++) @(negedge mclk);
      cur = nxt(cur);
      `CHK("start", 1'b1, conv_start)
      `CHK("busy", 1'b1, conv_busy)
      `CHK("channel", 5'(cur), conv_channel)
      // Done is raised only once the engine is waiting, and after a varied delay.
      repeat (1 + rnd() % 3) @(negedge mclk);
      conv_done = 1'b1;
      @(negedge mclk);
      conv_done = 1'b0;
      `CHK("done", 1'b0, conv_busy)
    end
    monitor_enable = 1'b0;
    repeat (20) @(negedge mclk) `CHK("idle", 1'b0, conv_start)
    $display("test round robin done");
    summarize();
  end

  // Whole run is a few hundred cycles; this limit is ample but cuts a hang short.
  initial begin
    #400_000;
    bad_count++;
    summarize();
  end
endmodule : mcgd_regs_tb

bind mcgd_regs mcgd_regs_chk #(.NUM_PINS(NUM_PINS), .NUM_ANALOG(NUM_ANALOG)) u_chk (.mclk,
  .rst, .sw_reset, .req, .rsp, .monitor_enable, .pin_direction_bit, .pin_level_sense,
  .gpio_o, .gpio_oe, .analog_output_on, .conv_done, .conv_start, .conv_channel, .conv_busy);
`undef CHK
`default_nettype wire
